// file: common/lic_pkg.sv
// Constants for the link indicator control block: register map,
// field positions, reset values, bus answers and flash timing.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package lic_pkg;

	// Register byte addresses
	localparam logic [7:0]  CTRL_OFS    = 8'h18;      // Indicator control
	localparam logic [7:0]  CFG_OFS     = 8'h1C;      // Stretch configuration
	localparam logic [7:0]  STAT_OFS    = 8'h20;      // Indicator status
	localparam int          ADDR_W      = 8;

	// Control register fields
	localparam int          RATE_LSB    = 9;
	localparam int          POL_BIT     = 7;
	localparam int          OVR_BIT     = 4;
	localparam int          FORCE_BIT   = 1;
	localparam logic [15:0] CTRL_RESET  = 16'h0400;
	localparam logic [15:0] CTRL_WMASK  = 16'h0692;

	// Configuration register fields
	localparam int          BYPASS_BIT  = 7;
	localparam logic [15:0] CFG_RESET   = 16'h0000;
	localparam logic [15:0] CFG_WMASK   = 16'h0080;

	// Status register fields
	localparam int          ST_PIN_BIT  = 0;
	localparam int          ST_BUSY_BIT = 1;
	localparam int          ST_LINK_BIT = 2;

	// Bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Flash timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_IN_NS      = 1000000;
	localparam int unsigned CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
	localparam logic [9:0]  FLASH_MS_0    = 10'h032;  // 50 ms
	localparam logic [9:0]  FLASH_MS_1    = 10'h064;  // 100 ms
	localparam logic [9:0]  FLASH_MS_2    = 10'h0C8;  // 200 ms
	localparam logic [9:0]  FLASH_MS_3    = 10'h1F4;  // 500 ms

	typedef enum logic [1:0] {FL_IDLE, FL_OFF, FL_ON} lic_flash_state_t;

	// Maps the rate field to a phase length in milliseconds
	function automatic logic [9:0] flash_ms(input logic [1:0] rate);
		case (rate)
			2'h0:    flash_ms = FLASH_MS_0;
			2'h1:    flash_ms = FLASH_MS_1;
			2'h2:    flash_ms = FLASH_MS_2;
			default: flash_ms = FLASH_MS_3;
		endcase
	endfunction : flash_ms

endpackage : lic_pkg

// file: hdl/lic_flash_timer.sv
// Flash timer: one off phase then one on phase of the selected length.
// Assumes the trigger is synchronous to clk_i.
`timescale 1ns/1ps
module lic_flash_timer #(
	parameter int unsigned CYCLES_PER_MS = lic_pkg::CYCLES_PER_MS
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [1:0] rate_i,
	input  wire logic       trigger_i,
	output logic            off_phase_o,
	output logic            busy_o
);
	import lic_pkg::*;

	lic_flash_state_t state_reg, state_next;
	logic [31:0]      cyc_reg, cyc_next;
	logic [9:0]       ms_reg, ms_next;
	logic [1:0]       rate_seen_reg, rate_seen_next;
	logic             ms_tick;
	logic             phase_done;

	// Millisecond tick and end of phase
	assign ms_tick    = (cyc_reg == 32'(CYCLES_PER_MS - 1));
	assign phase_done = ms_tick && (ms_reg == flash_ms(rate_i) - 10'h001); // R01

	// Next state of the phase sequencer
	always_comb begin
		state_next     = state_reg;
		cyc_next       = cyc_reg;
		ms_next        = ms_reg;
		rate_seen_next = rate_i;
		if (state_reg != FL_IDLE) begin
			cyc_next = ms_tick ? 32'h0000_0000 : cyc_reg + 32'h0000_0001; // R06
			if (ms_tick)
				ms_next = ms_reg + 10'h001;
		end
		case (state_reg)
			FL_IDLE: begin
				if (trigger_i) begin
					state_next = FL_OFF;
					cyc_next   = 32'h0000_0000;
					ms_next    = 10'h000;
				end
			end
			FL_OFF: begin
				if (phase_done) begin
					state_next = FL_ON;
					ms_next    = 10'h000;
				end
			end
			FL_ON: begin
				if (phase_done)
					state_next = FL_IDLE;
			end
			default: state_next = FL_IDLE;
		endcase
		// A new rate abandons the running flash
		if (rate_i != rate_seen_reg) begin // R06
			state_next = FL_IDLE;
			cyc_next   = 32'h0000_0000;
			ms_next    = 10'h000;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg     <= FL_IDLE;
			cyc_reg       <= 32'h0000_0000;
			ms_reg        <= 10'h000;
			rate_seen_reg <= CTRL_RESET[RATE_LSB+1:RATE_LSB];
		end else begin
			state_reg     <= state_next;
			cyc_reg       <= cyc_next;
			ms_reg        <= ms_next;
			rate_seen_reg <= rate_seen_next;
		end
	end

	assign off_phase_o = (state_reg == FL_OFF);
	assign busy_o      = (state_reg != FL_IDLE);

endmodule : lic_flash_timer

// file: hdl/lic_top.sv
// Link indicator control: AXI4-Lite register slave, polarity strap,
// override and pulse stretching for the first indicator pin.
// Assumes all inputs are synchronous to CLOCK_I and one master.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// R01: Rate field picks 50/100/200/500 ms, reset 2
// R02: Polarity from strap, then bit 7 overrides
// R03: Bit 4 set forces pin to bit 1
// R04: Forced level bit 1, reset zero
// R05: Stretch pulses unless bypass bit is one
// R06: Cycle counter times phases, restarts on rate change
module lic_top #(
	parameter int unsigned CYCLES_PER_MS = lic_pkg::CYCLES_PER_MS
) (
	input  wire logic                     CLOCK_I,
	input  wire logic                     RST_N_I,
	input  wire logic [lic_pkg::ADDR_W-1:0] AWADDR_I,
	input  wire logic                     AWVALID_I,
	output logic                          AWREADY_O,
	input  wire logic [31:0]              WDATA_I,
	input  wire logic [3:0]               WSTRB_I,
	input  wire logic                     WVALID_I,
	output logic                          WREADY_O,
	output logic [1:0]                    BRESP_O,
	output logic                          BVALID_O,
	input  wire logic                     BREADY_I,
	input  wire logic [lic_pkg::ADDR_W-1:0] ARADDR_I,
	input  wire logic                     ARVALID_I,
	output logic                          ARREADY_O,
	output logic [31:0]                   RDATA_O,
	output logic [1:0]                    RRESP_O,
	output logic                          RVALID_O,
	input  wire logic                     RREADY_I,
	input  wire logic                     LINK_I,
	input  wire logic                     ACTIVITY_I,
	input  wire logic                     POLARITY_STRAP_I,
	output logic                          FIRST_INDICATOR_PIN_O
);
	import lic_pkg::*;

	// Write channel state
	logic              awready_reg, awready_next;
	logic              wready_reg, wready_next;
	logic              aw_have_reg, aw_have_next;
	logic              w_have_reg, w_have_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [15:0]       w_data_reg, w_data_next;
	logic [1:0]        w_strb_reg, w_strb_next;
	logic              bvalid_reg, bvalid_next;
	logic [1:0]        bresp_reg, bresp_next;

	// Read channel state
	logic              arready_reg, arready_next;
	logic              rvalid_reg, rvalid_next;
	logic [31:0]       rdata_reg, rdata_next;
	logic [1:0]        rresp_reg, rresp_next;

	// Register file and indicator state
	logic [15:0]       ctrl_reg, ctrl_next;
	logic [15:0]       cfg_reg, cfg_next;
	logic              strap_done_reg, strap_done_next;
	logic              pin_reg, pin_next;
	logic [15:0]       wmask;
	logic              flash_off;
	logic              flash_busy;
	logic              level_raw;
	logic              level_str;
	logic              level;

	// Address decode shared by the write and read paths
	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		is_mapped = (addr == CTRL_OFS) || (addr == CFG_OFS) || (addr == STAT_OFS);
	endfunction : is_mapped

	// Flash timer for stretched activity
	lic_flash_timer #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) i_lic_flash_timer (
		.clk_i       (CLOCK_I),
		.rst_n_i     (RST_N_I),
		.rate_i      (ctrl_reg[RATE_LSB+1:RATE_LSB]),
		.trigger_i   (LINK_I & ACTIVITY_I),
		.off_phase_o (flash_off),
		.busy_o      (flash_busy)
	);

	// Bit mask for byte lanes 0 and 1 from the write strobes
	assign wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

	// Write path and register updates
	always_comb begin
		aw_have_next    = aw_have_reg;
		aw_addr_next    = aw_addr_reg;
		w_have_next     = w_have_reg;
		w_data_next     = w_data_reg;
		w_strb_next     = w_strb_reg;
		bvalid_next     = bvalid_reg;
		bresp_next      = bresp_reg;
		ctrl_next       = ctrl_reg;
		cfg_next        = cfg_reg;
		strap_done_next = 1'b1;
		// Strap is caught once, on the first edge after reset release
		if (!strap_done_reg)
			ctrl_next[POL_BIT] = POLARITY_STRAP_I; // R02
		if (AWVALID_I && awready_reg) begin
			aw_have_next = 1'b1;
			aw_addr_next = AWADDR_I;
		end
		if (WVALID_I && wready_reg) begin
			w_have_next = 1'b1;
			w_data_next = WDATA_I[15:0];
			w_strb_next = WSTRB_I[1:0];
		end
		if (bvalid_reg && BREADY_I)
			bvalid_next = 1'b0;
		// Commit once address and data are both held
		if (aw_have_reg && w_have_reg && !bvalid_reg) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			if (aw_addr_reg == CTRL_OFS) begin
				// Rate, polarity override, override enable, forced level
				ctrl_next = (ctrl_reg & ~(CTRL_WMASK & wmask))
					| (w_data_reg & CTRL_WMASK & wmask); // R01 R02 R03 R04
			end else if (aw_addr_reg == CFG_OFS) begin
				cfg_next = (cfg_reg & ~(CFG_WMASK & wmask))
					| (w_data_reg & CFG_WMASK & wmask); // R05
			end
		end
		awready_next = !aw_have_next && !bvalid_next;
		wready_next  = !w_have_next && !bvalid_next;
	end

	// Read path: one-cycle answer
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (rvalid_reg && RREADY_I)
			rvalid_next = 1'b0;
		if (ARVALID_I && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = is_mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
			case (ARADDR_I)
				CTRL_OFS: rdata_next = {16'h0000, ctrl_reg};
				CFG_OFS:  rdata_next = {16'h0000, cfg_reg};
				STAT_OFS: begin
					rdata_next              = 32'h0000_0000;
					rdata_next[ST_PIN_BIT]  = pin_reg;
					rdata_next[ST_BUSY_BIT] = flash_busy;
					rdata_next[ST_LINK_BIT] = LINK_I;
				end
				default:  rdata_next = 32'h0000_0000;
			endcase
		end
		arready_next = !rvalid_next;
	end

	// Indicator level: activity blanks the link lamp
	assign level_raw = LINK_I & ~ACTIVITY_I;
	assign level_str = LINK_I & ~flash_off;

	// Pin drive: override, then polarity, then stretch choice
	always_comb begin
		level = cfg_reg[BYPASS_BIT] ? level_raw : level_str; // R05
		if (ctrl_reg[OVR_BIT])
			pin_next = ctrl_reg[FORCE_BIT]; // R03 R04
		else
			pin_next = ctrl_reg[POL_BIT] ? level : ~level; // R02
	end

	// All state registers
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			awready_reg    <= 1'b0;
			wready_reg     <= 1'b0;
			aw_have_reg    <= 1'b0;
			w_have_reg     <= 1'b0;
			aw_addr_reg    <= '0;
			w_data_reg     <= 16'h0000;
			w_strb_reg     <= 2'h0;
			bvalid_reg     <= 1'b0;
			bresp_reg      <= RESP_OKAY;
			arready_reg    <= 1'b0;
			rvalid_reg     <= 1'b0;
			rdata_reg      <= 32'h0000_0000;
			rresp_reg      <= RESP_OKAY;
			ctrl_reg       <= CTRL_RESET; // R01 R04
			cfg_reg        <= CFG_RESET;
			strap_done_reg <= 1'b0;
			pin_reg        <= 1'b0;
		end else begin
			awready_reg    <= awready_next;
			wready_reg     <= wready_next;
			aw_have_reg    <= aw_have_next;
			w_have_reg     <= w_have_next;
			aw_addr_reg    <= aw_addr_next;
			w_data_reg     <= w_data_next;
			w_strb_reg     <= w_strb_next;
			bvalid_reg     <= bvalid_next;
			bresp_reg      <= bresp_next;
			arready_reg    <= arready_next;
			rvalid_reg     <= rvalid_next;
			rdata_reg      <= rdata_next;
			rresp_reg      <= rresp_next;
			ctrl_reg       <= ctrl_next;
			cfg_reg        <= cfg_next;
			strap_done_reg <= strap_done_next;
			pin_reg        <= pin_next;
		end
	end

	// Outputs straight from flip-flops
	assign AWREADY_O             = awready_reg;
	assign WREADY_O              = wready_reg;
	assign BVALID_O              = bvalid_reg;
	assign BRESP_O               = bresp_reg;
	assign ARREADY_O             = arready_reg;
	assign RVALID_O              = rvalid_reg;
	assign RDATA_O               = rdata_reg;
	assign RRESP_O               = rresp_reg;
	assign FIRST_INDICATOR_PIN_O = pin_reg;

endmodule : lic_top

// file: bench/lic_lamp_model.sv
// Indicator lamp model: glows when the pin is at its active level.
// Assumes the active level comes from the board strap.
`timescale 1ns/1ps
module lic_lamp_model (
	input  wire logic pin_i,
	input  wire logic active_high_i,
	output logic      lit_o
);
	// Lamp is lit at the active level only
	assign lit_o = pin_i ~^ active_high_i;
endmodule : lic_lamp_model

// file: bench/lic_assertions.sv
// Checker for lic_top: shadows the registers from bus traffic.
// Assumes full byte strobes on every register write.
`timescale 1ns/1ps
module lic_assertions #(
	parameter int unsigned CYCLES_PER_MS = 10
) (
	input wire logic                        CLOCK_I,
	input wire logic                        RST_N_I,
	input wire logic [lic_pkg::ADDR_W-1:0]  AWADDR_I,
	input wire logic                        AWVALID_I,
	input wire logic                        AWREADY_O,
	input wire logic [31:0]                 WDATA_I,
	input wire logic                        WVALID_I,
	input wire logic                        WREADY_O,
	input wire logic                        LINK_I,
	input wire logic                        ACTIVITY_I,
	input wire logic                        POLARITY_STRAP_I,
	input wire logic                        FIRST_INDICATOR_PIN_O
);
	import lic_pkg::*;
	logic [15:0] ctl_reg, cfg_reg, dat_reg;
	logic [7:0]  adr_reg;
	logic        aw_reg, w_reg, go_reg, chg_reg, ok_reg;
	int unsigned cnt_reg;
	int unsigned ms_tab [4] = '{50, 100, 200, 500};
	wire logic   pin = FIRST_INDICATOR_PIN_O;
	wire logic   commit = aw_reg && w_reg;
	wire logic   mode_ok = !ctl_reg[OVR_BIT] && !cfg_reg[BYPASS_BIT] && ctl_reg[POL_BIT];
	// Register shadow, rate-change flag and low-run counter
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctl_reg <= CTRL_RESET;
			cfg_reg <= CFG_RESET;
			{aw_reg, w_reg, go_reg, chg_reg, ok_reg} <= '0;
			{adr_reg, dat_reg} <= '0;
			cnt_reg <= 0;
		end else begin
			go_reg <= 1'b1;
			chg_reg <= 1'b0;
			if (!go_reg) ctl_reg[POL_BIT] <= POLARITY_STRAP_I;
			if (AWVALID_I && AWREADY_O) {aw_reg, adr_reg} <= {1'b1, AWADDR_I};
			if (WVALID_I && WREADY_O) {w_reg, dat_reg} <= {1'b1, WDATA_I[15:0]};
			if (commit) begin
				{aw_reg, w_reg} <= 2'h0;
				if (adr_reg == CTRL_OFS) ctl_reg <= dat_reg & CTRL_WMASK;
				if (adr_reg == CTRL_OFS) chg_reg <= dat_reg[10:9] != ctl_reg[10:9];
				if (adr_reg == CFG_OFS) cfg_reg <= dat_reg & CFG_WMASK;
			end
			cnt_reg <= pin ? 0 : cnt_reg + 1;
			ok_reg <= mode_ok && LINK_I && !commit && (pin || ok_reg);
		end
	end
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	property p_force;
		ctl_reg[OVR_BIT] |=> pin == $past(ctl_reg[FORCE_BIT]);
	endproperty
	a_force: assert property (p_force) else $error("forced level missing");
	property p_bypass;
		go_reg && !ctl_reg[OVR_BIT] && cfg_reg[BYPASS_BIT]
			|=> pin == ($past(ctl_reg[POL_BIT]) ~^ ($past(LINK_I) && !$past(ACTIVITY_I)));
	endproperty
	a_bypass: assert property (p_bypass) else $error("direct level wrong");
	property p_dark;
		go_reg && !ctl_reg[OVR_BIT] && !LINK_I |=> pin == !$past(ctl_reg[POL_BIT]);
	endproperty
	a_dark: assert property (p_dark) else $error("idle level wrong");
	property p_low_len;
		$rose(pin) && ok_reg |-> cnt_reg == ms_tab[ctl_reg[10:9]] * CYCLES_PER_MS;
	endproperty
	a_low_len: assert property (p_low_len) else $error("off phase length wrong");
	property p_restart;
		chg_reg && mode_ok && LINK_I && !ACTIVITY_I |-> ##[1:3] pin;
	endproperty
	a_restart: assert property (p_restart) else $error("flash not restarted");
	property p_blank;
		$fell(pin) && $past(mode_ok) && $past(LINK_I) |-> $past(ACTIVITY_I, 2);
	endproperty
	a_blank: assert property (p_blank) else $error("blink without event");
endmodule : lic_assertions
bind lic_top lic_assertions #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_lic_assertions (.CLOCK_I,
	.RST_N_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WVALID_I, .WREADY_O, .LINK_I,
	.ACTIVITY_I, .POLARITY_STRAP_I, .FIRST_INDICATOR_PIN_O);

// file: bench/lic_top_test.sv
// Bench for lic_top: bus tasks, case table, blink timing and abort.
// Assumes the checker binds itself and the lamp model is compiled.
`timescale 1ns/1ps
module lic_top_test;
	import lic_pkg::*;
	localparam int unsigned CPMS = 10;
	logic        CLOCK_I = 1'b0, RST_N_I = 1'b0;
	logic [7:0]  AWADDR_I = '0, ARADDR_I = '0;
	logic [31:0] WDATA_I = '0, RDATA_O, d;
	logic        AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0, ARVALID_I = 1'b0;
	logic        RREADY_I = 1'b0, LINK_I = 1'b0, ACTIVITY_I = 1'b0, lit, strap = 1'b1;
	logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, FIRST_INDICATOR_PIN_O;
	logic [1:0]  BRESP_O, RRESP_O, rsp;
	int          fails = 0, n_compared = 0, cycles = 0, n;
	int unsigned ms [4] = '{50, 100, 200, 500};
	// Rows: control word, link, activity, expected pin
	logic [18:0] rows [8] = '{{16'h0012, 3'b001}, {16'h0010, 3'b100}, {16'h0080, 3'b101},
		{16'h0080, 3'b000}, {16'h0080, 3'b110}, {16'h0000, 3'b100}, {16'h0000, 3'b001},
		{16'h0002, 3'b100}};
	lic_top #(.CYCLES_PER_MS(CPMS)) i_lic_top (.CLOCK_I, .RST_N_I, .AWADDR_I, .AWVALID_I,
		.AWREADY_O, .WDATA_I, .WSTRB_I(4'hF), .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O,
		.BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O,
		.RREADY_I, .LINK_I, .ACTIVITY_I, .POLARITY_STRAP_I(strap), .FIRST_INDICATOR_PIN_O);
	lic_lamp_model i_lic_lamp_model (.pin_i(FIRST_INDICATOR_PIN_O), .active_high_i(strap),
		.lit_o(lit));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	// Write: address and data together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
		logic b;
		@(posedge CLOCK_I);
		AWADDR_I <= a;
		WDATA_I <= {16'h0000, v};
		{AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
		b = 1'b0;
		while (!b) begin
			@(posedge CLOCK_I);
			if (AWREADY_O) AWVALID_I <= 1'b0;
			if (WREADY_O) WVALID_I <= 1'b0;
			b = BVALID_O;
			r = BRESP_O;
		end
		BREADY_I <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic g;
		@(posedge CLOCK_I);
		ARADDR_I <= a;
		{ARVALID_I, RREADY_I} <= 2'h3;
		g = 1'b0;
		while (!g) begin
			@(posedge CLOCK_I);
			if (ARREADY_O) ARVALID_I <= 1'b0;
			g = RVALID_O;
			v = RDATA_O;
			r = RRESP_O;
		end
		RREADY_I <= 1'b0;
	endtask : rd
	task automatic pulse();
		@(posedge CLOCK_I);
		ACTIVITY_I <= 1'b1;
		@(posedge CLOCK_I);
		ACTIVITY_I <= 1'b0;
	endtask : pulse
	initial begin
		forever #5 CLOCK_I = ~CLOCK_I;
	end
	// Cycle ceiling against hangs
	always @(posedge CLOCK_I) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge CLOCK_I);
		RST_N_I <= 1'b1;
		rd(CTRL_OFS, d, rsp);
		chk(d, 32'h00000480);
		chk(rsp, RESP_OKAY);
		rd(CFG_OFS, d, rsp);
		chk(d, 32'h00000000);
		rd(8'h40, d, rsp);
		chk({d[29:0], rsp}, {30'h0, RESP_SLVERR});
		wr(CTRL_OFS, 16'hFFFF, rsp);
		rd(CTRL_OFS, d, rsp);
		chk(d, 32'h00000692);
		wr(8'h00, 16'h0012, rsp);
		chk(rsp, RESP_SLVERR);
		wr(CFG_OFS, 16'h0080, rsp);
		foreach (rows[i]) begin
			{LINK_I, ACTIVITY_I} <= rows[i][2:1];
			wr(CTRL_OFS, rows[i][18:3], rsp);
			repeat (3) @(posedge CLOCK_I);
			chk(FIRST_INDICATOR_PIN_O, rows[i][0]);
			rd(CTRL_OFS, d, rsp);
			chk(d, {16'h0000, rows[i][18:3]});
		end
		{LINK_I, ACTIVITY_I} <= 2'h0;
		repeat (1100) @(posedge CLOCK_I);
		wr(CFG_OFS, 16'h0000, rsp);
		LINK_I <= 1'b1;
		for (int r = 0; r < 4; r++) begin
			wr(CTRL_OFS, 16'h0080 | 16'(r << 9), rsp);
			pulse();
			while (FIRST_INDICATOR_PIN_O !== 1'b0) @(posedge CLOCK_I);
			n = 0;
			while (FIRST_INDICATOR_PIN_O === 1'b0) begin
				n++;
				@(posedge CLOCK_I);
			end
			chk(n, ms[r] * CPMS);
			pulse();
			repeat (3) @(posedge CLOCK_I);
			chk(FIRST_INDICATOR_PIN_O, 1'b1);
			repeat (ms[r] * CPMS) @(posedge CLOCK_I);
		end
		pulse();
		repeat (20) @(posedge CLOCK_I);
		chk(FIRST_INDICATOR_PIN_O, 1'b0);
		// Status mid off phase: pin low, flash busy, link up
		rd(STAT_OFS, d, rsp);
		chk(d, (32'h1 << ST_BUSY_BIT) | (32'h1 << ST_LINK_BIT));
		wr(CTRL_OFS, 16'h0080, rsp);
		repeat (3) @(posedge CLOCK_I);
		chk(lit, 1'b1);
		// Mid-run reset with the strap low: active-low lamp
		strap <= 1'b0;
		LINK_I <= 1'b0;
		RST_N_I <= 1'b0;
		repeat (3) @(posedge CLOCK_I);
		RST_N_I <= 1'b1;
		rd(CTRL_OFS, d, rsp);
		chk(d, {16'h0000, CTRL_RESET});
		repeat (2) @(posedge CLOCK_I);
		chk(FIRST_INDICATOR_PIN_O, 1'b1);
		chk(lit, 1'b0);
		LINK_I <= 1'b1;
		repeat (3) @(posedge CLOCK_I);
		chk(FIRST_INDICATOR_PIN_O, 1'b0);
		chk(lit, 1'b1);
		give_verdict();
	end
endmodule : lic_top_test
